// [hw/instruction_field_decoder.sv]
// Operand field decoder for 24-bit core instruction words
`timescale 1ns/1ps

// What this block does
// - Accumulator bit: 0 first, 1 second
// - Byte bit: 0 word, 1 byte
// - Bit position 0000 LSB to 1111 MSB
// - Destination bit: 0 default register, 1 file
// - Destination field indexes working registers 0-15
// - Decode 13-bit file register address
// - File word address has implied zero LSB
// - Assemble 23-bit absolute program address
// - 16-bit offset for relative branch/call
// - Source field indexes working registers 0-15
// - Base field indexes working registers 0-15
// - Double-word bit: 0 single, 1 double
// - Bit test into carry 0, zero 1
// - Source mode: six modes, 11x unused in the plain format
// - Destination mode 11x forces device reset in the plain format
// - Offset source mode 11x adds base register
// - Offset destination mode 11x adds base register
// - X prefetch operation through registers 8/9
// - Y prefetch operation through registers 10/11
// - X prefetch target registers 4 to 7
// - Literal fields of 8 and 16 bits from bit 4; the 10-bit field at bit 4 and the 1, 4, 6 and 14-bit fields at bit 0 are not captured
// - Engine flags (fetch, offset add, accumulator, pair invalid, store) decoded only with engine present
// - Y prefetch target registers 4 to 7
// - Squaring field selects registers 4 to 7
// - Multiplier pair table; 011, 111 invalid
// - Store-back field: direct, indirect+2, none, invalid
module instruction_field_decoder (
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst_b,
	// Register port
	input  wire logic [3:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output      logic [31:0]          reg_rdata,
	// From the fetch stage
	input  wire logic                 instr_valid,
	input  wire logic [23:0]          instr_word,
	input  wire logic [23:0]          ext_word,
	input  wire logic                 offset_format,
	// Decoded controls, loaded with each valid word
	output      logic                 dec_valid_ff,
	output      logic                 second_accumulator_ff,
	output      logic                 byte_op_ff,
	output      logic [15:0]          bit_mask_ff,
	output      logic                 to_file_ff,
	output      logic                 to_default_working_register_ff,
	output      logic [15:0]          destination_working_register_ff,
	output      logic [15:0]          source_working_register_ff,
	output      logic [15:0]          base_working_register_ff,
	output      logic [12:0]          file_addr_ff,
	output      logic [15:0]          file_word_addr_ff,
	output      logic [22:0]          prog_addr_ff,
	output      logic [15:0]          rel_offset_ff,
	output      logic                 dword_op_ff,
	output      logic                 test_to_zero_ff,
	output      logic [7:0]           src_mode_ff,
	output      logic [7:0]           dst_mode_ff,
	output      logic                 force_reset_ff,
	output      logic [23:0]          literal_ff,
	// Multiply-accumulate engine controls
	output      logic                 x_fetch_ff,
	output      logic [3:0]           x_ptr_ff,
	output      logic [3:0]           x_step_ff,
	output      logic                 x_add_offset_ff,
	output      logic [3:0]           x_prefetch_target_ff,
	output      logic                 y_fetch_ff,
	output      logic [3:0]           y_ptr_ff,
	output      logic [3:0]           y_step_ff,
	output      logic                 y_add_offset_ff,
	output      logic [3:0]           y_prefetch_target_ff,
	output      logic [3:0]           square_reg_ff,
	output      logic [3:0]           mult_a_ff,
	output      logic [3:0]           mult_b_ff,
	output      logic                 mult_invalid_ff,
	output      logic                 store_direct_ff,
	output      logic                 store_indirect_ff,
	output      logic                 store_invalid_ff,
	output      logic [3:0]           store_reg_ff
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	function automatic logic [7:0] mode_of(input logic [2:0] code, input logic offs);
		logic [7:0] m;
		m = 8'h00;
		case (code)
			3'h0: m = field_decode_pkg::mode_direct;
			3'h1: m = field_decode_pkg::mode_ind;
			3'h2: m = field_decode_pkg::mode_postdec;
			3'h3: m = field_decode_pkg::mode_postinc;
			3'h4: m = field_decode_pkg::mode_predec;
			3'h5: m = field_decode_pkg::mode_preinc;
			default: m = offs ? field_decode_pkg::mode_offset : field_decode_pkg::mode_unused;
		endcase
		return m;
	endfunction : mode_of

	// Pointer step in bytes, two's complement; word steps keep alignment
	function automatic logic [3:0] step_of(input logic [2:0] code);
		logic [3:0] s;
		s = 4'h0;
		case (code)
			3'h1: s = 4'h2;
			3'h2: s = 4'h4;
			3'h3: s = 4'h6;
			3'h5: s = 4'hA;
			3'h6: s = 4'hC;
			3'h7: s = 4'hE;
			default: s = 4'h0;
		endcase
		return s;
	endfunction : step_of

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	logic        dsp_en_ff;
	logic [31:0] nxt_rdata;
	wire         ctrl_hit   = reg_addr == field_decode_pkg::CTRL_OFS;
	wire         status_hit = reg_addr == field_decode_pkg::STATUS_OFS;

	// Status shows the latched decode so software can see the block's state
	assign nxt_rdata = ctrl_hit   ? {31'h0, dsp_en_ff} :
	                   status_hit ? {12'h0, store_invalid_ff, mult_invalid_ff,
	                                 force_reset_ff, dec_valid_ff, dst_mode_ff, src_mode_ff} :
	                   32'h0;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			dsp_en_ff <= field_decode_pkg::CTRL_RST;
			reg_rdata <= 32'h0;
		end else begin
			if (reg_wr && ctrl_hit) begin
				dsp_en_ff <= reg_wdata[0];
			end
			reg_rdata <= reg_rd ? nxt_rdata : 32'h0;
		end
	end

	// ----------------------------------------------------------------
	// Plain field extraction
	// ----------------------------------------------------------------
	wire [3:0] src_code  = instr_word[field_decode_pkg::SRC_REG_LSB +: 4];
	wire [3:0] dst_code  = instr_word[field_decode_pkg::DST_REG_LSB +: 4];
	wire [3:0] base_code = instr_word[field_decode_pkg::BASE_REG_LSB +: 4];
	wire [3:0] bpos_code = instr_word[field_decode_pkg::BIT_POS_LSB +: 4];
	wire [2:0] smode     = instr_word[field_decode_pkg::SRC_MODE_LSB +: 3];
	wire [2:0] dmode     = instr_word[field_decode_pkg::DST_MODE_LSB +: 3];

	logic [15:0] nxt_src_hot;
	logic [15:0] nxt_dst_hot;
	logic [15:0] nxt_base_hot;
	logic [15:0] nxt_bit_mask;

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_hot
			assign nxt_src_hot[gi]  = src_code == 4'(gi);
			assign nxt_dst_hot[gi]  = dst_code == 4'(gi);
			assign nxt_base_hot[gi] = base_code == 4'(gi);
			assign nxt_bit_mask[gi] = bpos_code == 4'(gi);
		end
	endgenerate

	wire [7:0] nxt_src_mode = mode_of(smode, offset_format);
	wire [7:0] nxt_dst_mode = mode_of(dmode, offset_format);
	// Unused destination codes in the plain format trap to a reset
	wire       nxt_force    = instr_valid && !offset_format && dmode[2:1] == 2'h3;

	wire [15:0] nxt_fword   = {instr_word[field_decode_pkg::FWORD_LSB +: 15], 1'b0};
	wire [22:0] nxt_paddr   = {ext_word[field_decode_pkg::PADDR_HI_LSB +: 7],
	                           instr_word[field_decode_pkg::PADDR_LO_LSB +: 15], 1'b0};

	// Literal holds the 16-bit and the 8-bit field, both from bit 4; the datapath picks one
	wire [23:0] nxt_literal = {instr_word[field_decode_pkg::LIT16_LSB +: 16],
	                           instr_word[field_decode_pkg::LIT8_LSB +: 8]};

	// ----------------------------------------------------------------
	// Multiply-accumulate fields; enable and flag outputs gated by engine presence
	// ----------------------------------------------------------------
	wire [3:0] xop   = instr_word[field_decode_pkg::XOP_LSB +: 4];
	wire [3:0] yop   = instr_word[field_decode_pkg::YOP_LSB +: 4];
	wire [1:0] xdst  = instr_word[field_decode_pkg::XDST_LSB +: 2];
	wire [1:0] ydst  = instr_word[field_decode_pkg::YDST_LSB +: 2];
	wire [1:0] store = instr_word[field_decode_pkg::STORE_LSB +: 2];
	wire [2:0] mult  = instr_word[field_decode_pkg::MULT_LSB +: 3];

	wire x_special = xop[2:0] == field_decode_pkg::PF_SPECIAL;
	wire y_special = yop[2:0] == field_decode_pkg::PF_SPECIAL;
	// Code 0100 idles the bus; 1100 is the offset read
	wire nxt_x_fetch  = dsp_en_ff && !(x_special && !xop[3]);
	wire nxt_y_fetch  = dsp_en_ff && !(y_special && !yop[3]);
	wire nxt_second_acc = dsp_en_ff && instr_word[field_decode_pkg::ACC_BIT];
	wire [3:0] nxt_x_ptr = xop[3] ? field_decode_pkg::X_PTR_HI : field_decode_pkg::X_PTR_LO;
	wire [3:0] nxt_y_ptr = yop[3] ? field_decode_pkg::Y_PTR_HI : field_decode_pkg::Y_PTR_LO;

	// Pair table: the two operand indexes per code, invalid codes flagged
	logic [3:0] nxt_ma;
	logic [3:0] nxt_mb;
	logic       nxt_minv;
	always_comb begin
		nxt_ma   = 4'h4;
		nxt_mb   = 4'h5;
		nxt_minv = 1'b0;
		case (mult)
			3'h0: begin
				nxt_ma = 4'h4;
				nxt_mb = 4'h5;
			end
			3'h1: begin
				nxt_ma = 4'h4;
				nxt_mb = 4'h6;
			end
			3'h2: begin
				nxt_ma = 4'h4;
				nxt_mb = 4'h7;
			end
			3'h4: begin
				nxt_ma = 4'h5;
				nxt_mb = 4'h6;
			end
			3'h5: begin
				nxt_ma = 4'h5;
				nxt_mb = 4'h7;
			end
			3'h6: begin
				nxt_ma = 4'h6;
				nxt_mb = 4'h7;
			end
			default: nxt_minv = 1'b1;
		endcase
	end

	// ----------------------------------------------------------------
	// Decode pipeline register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			dec_valid_ff   <= 1'b0;
			force_reset_ff <= 1'b0;
		end else begin
			dec_valid_ff   <= instr_valid;
			force_reset_ff <= nxt_force;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			second_accumulator_ff           <= 1'b0;
			byte_op_ff                      <= 1'b0;
			bit_mask_ff                     <= 16'h0;
			to_file_ff                      <= 1'b0;
			to_default_working_register_ff  <= 1'b0;
			destination_working_register_ff <= 16'h0;
			source_working_register_ff      <= 16'h0;
			base_working_register_ff        <= 16'h0;
			file_addr_ff                    <= 13'h0;
			file_word_addr_ff               <= 16'h0;
			prog_addr_ff                    <= 23'h0;
			rel_offset_ff                   <= 16'h0;
			dword_op_ff                     <= 1'b0;
			test_to_zero_ff                 <= 1'b0;
			src_mode_ff                     <= 8'h0;
			dst_mode_ff                     <= 8'h0;
			literal_ff                      <= 24'h0;
		end else if (instr_valid) begin
			second_accumulator_ff           <= nxt_second_acc;
			byte_op_ff                      <= instr_word[field_decode_pkg::BYTE_BIT];
			bit_mask_ff                     <= nxt_bit_mask;
			to_file_ff                      <= instr_word[field_decode_pkg::DEST_F_BIT];
			to_default_working_register_ff  <= !instr_word[field_decode_pkg::DEST_F_BIT];
			destination_working_register_ff <= nxt_dst_hot;
			source_working_register_ff      <= nxt_src_hot;
			base_working_register_ff        <= nxt_base_hot;
			file_addr_ff                    <= instr_word[field_decode_pkg::FILE_LSB +: 13];
			file_word_addr_ff               <= nxt_fword;
			prog_addr_ff                    <= nxt_paddr;
			rel_offset_ff                   <= instr_word[field_decode_pkg::REL_LSB +: 16];
			dword_op_ff                     <= instr_word[field_decode_pkg::DWORD_BIT];
			test_to_zero_ff                 <= instr_word[field_decode_pkg::TEST_Z_BIT];
			src_mode_ff                     <= nxt_src_mode;
			dst_mode_ff                     <= nxt_dst_mode;
			literal_ff                      <= nxt_literal;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			x_fetch_ff           <= 1'b0;
			x_ptr_ff             <= 4'h0;
			x_step_ff            <= 4'h0;
			x_add_offset_ff      <= 1'b0;
			x_prefetch_target_ff <= 4'h0;
			y_fetch_ff           <= 1'b0;
			y_ptr_ff             <= 4'h0;
			y_step_ff            <= 4'h0;
			y_add_offset_ff      <= 1'b0;
			y_prefetch_target_ff <= 4'h0;
			square_reg_ff        <= 4'h0;
			mult_a_ff            <= 4'h0;
			mult_b_ff            <= 4'h0;
			mult_invalid_ff      <= 1'b0;
			store_direct_ff      <= 1'b0;
			store_indirect_ff    <= 1'b0;
			store_invalid_ff     <= 1'b0;
			store_reg_ff         <= 4'h0;
		end else if (instr_valid) begin
			x_fetch_ff           <= nxt_x_fetch;
			x_ptr_ff             <= nxt_x_ptr;
			x_step_ff            <= step_of(xop[2:0]);
			x_add_offset_ff      <= dsp_en_ff && x_special && xop[3];
			x_prefetch_target_ff <= field_decode_pkg::MAC_REG_BASE + {2'h0, xdst};
			y_fetch_ff           <= nxt_y_fetch;
			y_ptr_ff             <= nxt_y_ptr;
			y_step_ff            <= step_of(yop[2:0]);
			y_add_offset_ff      <= dsp_en_ff && y_special && yop[3];
			y_prefetch_target_ff <= field_decode_pkg::MAC_REG_BASE + {2'h0, ydst};
			square_reg_ff        <= field_decode_pkg::MAC_REG_BASE + {2'h0, mult[1:0]};
			mult_a_ff            <= nxt_ma;
			mult_b_ff            <= nxt_mb;
			mult_invalid_ff      <= dsp_en_ff && nxt_minv;
			store_direct_ff      <= dsp_en_ff && store == 2'h0;
			store_indirect_ff    <= dsp_en_ff && store == 2'h1;
			store_invalid_ff     <= dsp_en_ff && store == 2'h3;
			store_reg_ff         <= field_decode_pkg::STORE_REG;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence s_bad_dst;
		instr_valid && !offset_format && instr_word[13:12] == 2'h3;
	endsequence

	sequence s_trap_pulse;
		force_reset_ff && dec_valid_ff;
	endsequence

	a_acc_select: assert property (instr_valid && dsp_en_ff |=>
		second_accumulator_ff == $past(instr_word[15])) else $error("accumulator select wrong");
	a_byte_mode: assert property (instr_valid |=>
		byte_op_ff == $past(instr_word[14])) else $error("byte mode wrong");
	a_bit_mask: assert property (instr_valid |=>
		bit_mask_ff == 16'(16'h1 << $past(instr_word[15:12]))) else $error("bit mask wrong");
	a_dest_route: assert property (instr_valid |=>
		to_file_ff != to_default_working_register_ff && to_file_ff == $past(instr_word[13]))
		else $error("destination route wrong");
	a_word_even: assert property (instr_valid |=>
		file_word_addr_ff == {$past(instr_word[18:4]), 1'b0}) else $error("word address wrong");
	a_prog_addr: assert property (instr_valid |=>
		prog_addr_ff == {$past(ext_word[6:0]), $past(instr_word[15:1]), 1'b0})
		else $error("program address wrong");
	a_src_reg: assert property (instr_valid |=>
		source_working_register_ff == 16'(16'h1 << $past(instr_word[3:0])))
		else $error("source register wrong");
	a_dst_trap: assert property (s_bad_dst |=> s_trap_pulse)
		else $error("reset trap missing");
	a_no_trap: assert property (
		!(instr_valid && !offset_format && instr_word[13:12] == 2'h3)
		|=> !force_reset_ff) else $error("spurious reset trap");
	a_offset_mode: assert property (instr_valid && offset_format && instr_word[6:5] == 2'h3
		|=> src_mode_ff == field_decode_pkg::mode_offset) else $error("offset mode wrong");
	a_x_idle: assert property (instr_valid && instr_word[9:6] == 4'h4 |=> !x_fetch_ff)
		else $error("x prefetch not idle");
	a_x_target: assert property (instr_valid |=>
		x_prefetch_target_ff == 4'h4 + {2'h0, $past(instr_word[13:12])})
		else $error("x target wrong");
	a_engine_gate: assert property (!dsp_en_ff && instr_valid |=>
		!x_fetch_ff && !y_fetch_ff && !second_accumulator_ff && !store_direct_ff)
		else $error("engine fields decoded without engine");
	a_pair_invalid: assert property (instr_valid && dsp_en_ff && instr_word[17:16] == 2'h3
		|=> mult_invalid_ff) else $error("invalid pair not flagged");
	a_store_code: assert property (instr_valid && dsp_en_ff |=>
		{store_direct_ff, store_indirect_ff, store_invalid_ff, store_reg_ff} ==
		{$past(instr_word[1:0]) == 2'h0, $past(instr_word[1:0]) == 2'h1,
		$past(instr_word[1:0]) == 2'h3, 4'hD}) else $error("store-back decode wrong");

endmodule : instruction_field_decoder

// [hw/field_decode_pkg.sv]
// Constants and types shared by the instruction field decoder
package field_decode_pkg;

	// ----------------------------------------------------------------
	// Field positions inside the 24-bit instruction word
	// ----------------------------------------------------------------
	localparam int unsigned WORD_W       = 24;
	localparam int unsigned SRC_REG_LSB  = 0;
	localparam int unsigned SRC_MODE_LSB = 4;
	localparam int unsigned DST_REG_LSB  = 7;
	localparam int unsigned DST_MODE_LSB = 11;
	localparam int unsigned BYTE_BIT     = 14;
	localparam int unsigned BASE_REG_LSB = 15;
	localparam int unsigned BIT_POS_LSB  = 12;
	localparam int unsigned TEST_Z_BIT   = 11;
	localparam int unsigned DEST_F_BIT   = 13;
	localparam int unsigned DWORD_BIT    = 6;
	localparam int unsigned FILE_LSB     = 0;
	localparam int unsigned FWORD_LSB    = 4;
	localparam int unsigned PADDR_LO_LSB = 1;
	localparam int unsigned PADDR_HI_LSB = 0;
	localparam int unsigned REL_LSB      = 0;
	// Multiply-accumulate word layout
	localparam int unsigned ACC_BIT      = 15;
	localparam int unsigned XDST_LSB     = 12;
	localparam int unsigned YDST_LSB     = 10;
	localparam int unsigned XOP_LSB      = 6;
	localparam int unsigned YOP_LSB      = 2;
	localparam int unsigned STORE_LSB    = 0;
	localparam int unsigned MULT_LSB     = 16;
	// Literal fields
	localparam int unsigned LIT1_LSB     = 0;
	localparam int unsigned LIT4_LSB     = 0;
	localparam int unsigned LIT6_LSB     = 0;
	localparam int unsigned LIT8_LSB     = 4;
	localparam int unsigned LIT10_LSB    = 4;
	localparam int unsigned LIT14_LSB    = 0;
	localparam int unsigned LIT16_LSB    = 4;

	// ----------------------------------------------------------------
	// Register port map and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] CTRL_OFS      = 4'h0;
	localparam logic [3:0] STATUS_OFS    = 4'h4;
	localparam logic       CTRL_RST      = 1'h1;

	// ----------------------------------------------------------------
	// Prefetch pointer registers and sub-codes
	// ----------------------------------------------------------------
	localparam logic [3:0] X_PTR_LO      = 4'h8;
	localparam logic [3:0] X_PTR_HI      = 4'h9;
	localparam logic [3:0] Y_PTR_LO      = 4'hA;
	localparam logic [3:0] Y_PTR_HI      = 4'hB;
	localparam logic [3:0] PF_OFFSET_REG = 4'hC;
	localparam logic [3:0] STORE_REG     = 4'hD;
	localparam logic [3:0] MAC_REG_BASE  = 4'h4;
	localparam logic [2:0] PF_SPECIAL    = 3'h4;

	typedef enum logic [7:0] {
		mode_direct  = 8'h01,
		mode_ind     = 8'h02,
		mode_postdec = 8'h04,
		mode_postinc = 8'h08,
		mode_predec  = 8'h10,
		mode_preinc  = 8'h20,
		mode_offset  = 8'h40,
		mode_unused  = 8'h80
	} addr_mode_type;

endpackage : field_decode_pkg

// [verif/fetch_model.sv]
// Fetch stage model that hands instruction words to the field decoder
`timescale 1ns/1ps
module fetch_model (
	// Clock
	input  wire logic        sys_clk,
	// Word to decode
	output      logic        instr_valid,
	output      logic [23:0] instr_word,
	output      logic [23:0] ext_word,
	output      logic        offset_format
);
	initial begin
		instr_valid   = 1'h0;
		instr_word    = 24'h0;
		ext_word      = 24'h0;
		offset_format = 1'h0;
	end

	// Idle lines show the inverse, so a stale word can never pass for the last one
	task automatic send(input logic [23:0] w, input logic [23:0] e, input logic o);
		@(posedge sys_clk);
		instr_valid   <= 1'h1;
		instr_word    <= w;
		ext_word      <= e;
		offset_format <= o;
		@(posedge sys_clk);
		instr_valid   <= 1'h0;
		instr_word    <= ~w;
		ext_word      <= ~e;
		offset_format <= ~o;
		#1;
	endtask : send
endmodule : fetch_model

// [verif/instruction_field_decoder_tb.sv]
// Self-checking bench for the instruction field decoder
`timescale 1ns/1ps
module instruction_field_decoder_tb;
	typedef struct packed {
		logic [23:0] w;
		logic        o;
		logic [7:0]  sm;
		logic [7:0]  dm;
		logic        fr;
	} row_type;
	logic        sys_clk = 1'h0;
	logic        rst_b = 1'h0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'h0;
	logic        reg_rd = 1'h0;
	logic [31:0] reg_rdata;
	logic        instr_valid, offset_format;
	logic [23:0] instr_word, ext_word, literal_ff;
	logic dec_valid_ff, second_accumulator_ff, byte_op_ff, to_file_ff, dword_op_ff;
	logic to_default_working_register_ff, test_to_zero_ff, force_reset_ff, mult_invalid_ff;
	logic x_fetch_ff, x_add_offset_ff, y_fetch_ff, y_add_offset_ff;
	logic store_direct_ff, store_indirect_ff, store_invalid_ff;
	logic [15:0] bit_mask_ff, destination_working_register_ff, source_working_register_ff;
	logic [15:0] base_working_register_ff, file_word_addr_ff, rel_offset_ff;
	logic [12:0] file_addr_ff;
	logic [22:0] prog_addr_ff;
	logic [7:0]  src_mode_ff, dst_mode_ff;
	logic [3:0]  x_ptr_ff, x_step_ff, x_prefetch_target_ff, y_ptr_ff, y_step_ff;
	logic [3:0]  y_prefetch_target_ff, square_reg_ff, mult_a_ff, mult_b_ff, store_reg_ff;
	wire [5:0]   flags = {second_accumulator_ff, byte_op_ff, to_file_ff,
		to_default_working_register_ff, dword_op_ff, test_to_zero_ff};
	wire [17:0]  modes = {dec_valid_ff, src_mode_ff, dst_mode_ff, force_reset_ff};
	wire [31:0]  xb = {22'h0, x_fetch_ff, x_ptr_ff, x_step_ff, x_add_offset_ff};
	wire [31:0]  yb = {22'h0, y_fetch_ff, y_ptr_ff, y_step_ff, y_add_offset_ff};
	wire [31:0]  tb = {20'h0, x_prefetch_target_ff, y_prefetch_target_ff, square_reg_ff};
	wire [31:0]  sb = {25'h0, store_direct_ff, store_indirect_ff, store_invalid_ff, store_reg_ff};
	logic [3:0]  steps [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h0, 4'hA, 4'hC, 4'hE};
	logic [7:0]  pairs [8] = '{8'h45, 8'h46, 8'h47, 8'h00, 8'h56, 8'h57, 8'h67, 8'h00};
	row_type     rows [7] = '{'{24'h000000, 1'h0, 8'h01, 8'h01, 1'h0},
		'{24'h001830, 1'h0, 8'h08, 8'h08, 1'h0}, '{24'h002850, 1'h0, 8'h20, 8'h20, 1'h0},
		'{24'h001040, 1'h0, 8'h10, 8'h04, 1'h0}, '{24'h003860, 1'h1, 8'h40, 8'h40, 1'h0},
		'{24'h000870, 1'h0, 8'h80, 8'h02, 1'h0}, '{24'h003010, 1'h0, 8'h02, 8'h80, 1'h1}};
	int          fail_count = 0;
	int          n_tests = 0;
	int          cycles = 0;

	instruction_field_decoder u_dut (.*);
	fetch_model u_fetch (.*);

	always #10 sys_clk = ~sys_clk;

	// A hang counts as a mismatch
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 1000) begin
			fail_count++;
			end_of_test();
		end
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1'h1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr    <= 1'h0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		reg_rd   <= 1'h1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd   <= 1'h0;
		#1;
		cmp(reg_rdata, exp);
	endtask : rd

	task automatic fields(input logic [5:0] f, input logic [15:0] oh, input logic [28:0] fa,
		input logic [22:0] pa, input logic [15:0] ro);
		cmp({26'h0, flags}, {26'h0, f});
		cmp({bit_mask_ff, destination_working_register_ff}, {oh, oh});
		cmp({source_working_register_ff, base_working_register_ff}, {oh, oh});
		cmp({3'h0, file_addr_ff, file_word_addr_ff}, {3'h0, fa});
		cmp({9'h0, prog_addr_ff}, {9'h0, pa});
		cmp({16'h0, rel_offset_ff}, {16'h0, ro});
	endtask : fields

	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	initial begin
		row_type     r;
		logic [23:0] w;
		logic [3:0]  c;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'h1;
		rd(4'h0, 32'h1);
		rd(4'h8, 32'h0);
		for (int i = 0; i < 7; i++) begin
			r = rows[i];
			u_fetch.send(r.w, 24'h0, r.o);
			cmp({14'h0, modes}, {14'h0, 1'h1, r.sm, r.dm, r.fr});
		end
		@(posedge sys_clk);
		#1;
		cmp({30'h0, dec_valid_ff, force_reset_ff}, 32'h0);
		$display("done: addressing modes");
		u_fetch.send(24'hFFFFFF, 24'h00007F, 1'h0);
		fields(6'h3B, 16'h8000, {13'h1FFF, 16'hFFFE}, 23'h7FFFFE, 16'hFFFF);
		u_fetch.send(24'h000000, 24'h000000, 1'h0);
		fields(6'h04, 16'h0001, 29'h0, 23'h0, 16'h0);
		$display("done: operand fields");
		for (int i = 0; i < 16; i++) begin
			c = i[3:0];
			w = {5'h0, c[2:0], 2'h0, c[1:0], c[1:0], c, c, c[1:0]};
			u_fetch.send(w, 24'h0, 1'h0);
			cmp(xb, {22'h0, c != 4'h4, 3'h4, c[3], steps[c[2:0]], c == 4'hC});
			cmp(yb, {22'h0, c != 4'h4, 3'h5, c[3], steps[c[2:0]], c == 4'hC});
			cmp(tb, {20'h0, {3{2'h1, c[1:0]}}});
			if (c[1:0] != 2'h3) cmp({24'h0, mult_a_ff, mult_b_ff}, {24'h0, pairs[c[2:0]]});
			cmp({31'h0, mult_invalid_ff}, {31'h0, c[1:0] == 2'h3});
			cmp(sb, {25'h0, c[1:0] == 2'h0, c[1:0] == 2'h1, c[1:0] == 2'h3, 4'hD});
			cmp({8'h0, literal_ff}, {8'h0, w[19:4], w[11:4]});
		end
		$display("done: engine fields");
		wr(4'h0, 32'h0);
		rd(4'h0, 32'h0);
		wr(4'h4, 32'hFFFFFFFF);
		u_fetch.send(24'h000000, 24'h0, 1'h0);
		cmp({30'h0, x_fetch_ff, y_fetch_ff}, 32'h0);
		rd(4'h4, 32'h00000101);
		wr(4'h0, 32'h1);
		u_fetch.send(24'h000000, 24'h0, 1'h0);
		cmp({30'h0, x_fetch_ff, y_fetch_ff}, 32'h3);
		$display("done: engine gate and registers");
		// Engine off first, so a read of 1 after reset proves the reset value
		wr(4'h0, 32'h0);
		@(posedge sys_clk);
		rst_b <= 1'h0;
		#1;
		cmp({30'h0, x_fetch_ff, to_default_working_register_ff}, 32'h0);
		cmp(reg_rdata, 32'h0);
		@(posedge sys_clk);
		rst_b <= 1'h1;
		rd(4'h0, 32'h1);
		$display("done: mid-run reset");
		end_of_test();
	end
endmodule : instruction_field_decoder_tb
